// ==== logic/dosc_pkg.sv ====
// Shared constants and types for the dual oscillator clock control block.
// Assumes a single 25 MHz system clock and an AHB-Lite register bus.
package dosc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [31:0] OSC_CTRL_ADDR = 32'h0000_0f70;
    localparam logic [31:0] OSC_STAT_ADDR = 32'h0000_0f74;
    localparam logic [3:0] OSC_CTRL_RESET = 4'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int FAST_STABLE_US = 5000;
    localparam int VSEL_HOLD_US = 5000;
    // Least times, rounded up to whole cycles
    localparam int FAST_STABLE_CYCLES = (FAST_STABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VSEL_HOLD_CYCLES = (VSEL_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // A 5-clock instruction lasts its clock count over the CPU clock rate
    localparam int INSTR_CLOCKS = 5;
    localparam int INSTR5_SLOW_NS = 152600;
    localparam int INSTR5_1MHZ_NS = 5000;
    localparam int INSTR5_2MHZ_NS = 2500;

    // ----------------------------------------------------------------
    // Synchroniser lanes
    // ----------------------------------------------------------------
    localparam int SYNC_SLOW = 0;
    localparam int SYNC_FAST = 1;
    localparam int SYNC_RC = 2;
    localparam int SYNC_W = 3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cpu_clock_select;
        logic fast_osc_enable;
        logic core_voltage_select_hi;
        logic core_voltage_select_lo;
    } dosc_ctrl_type;

    typedef struct packed {
        logic voltage_settled;
        logic switching;
        logic cpu_on_fast;
        logic fast_osc_stable;
    } dosc_stat_type;

    typedef enum logic [1:0] {
        LVL_1V2 = 2'h0,
        LVL_2V1 = 2'h1,
        LVL_3V0 = 2'h2
    } dosc_level_type;

    typedef enum logic [1:0] {
        SW_RUN = 2'h0,
        SW_PARK = 2'h1,
        SW_WAIT = 2'h3,
        SW_SETTLE = 2'h2
    } dosc_sw_type;

endpackage

// ==== logic/dosc_sync.sv ====
// Two-flop synchroniser for a vector of unrelated single-bit levels.
// Assumes each bit is an independent level; no multi-bit coherence.
`timescale 1ns/1ps
module dosc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// ==== logic/dosc_ctrl.sv ====
// Dual oscillator clock control: oscillation control register, core
// supply level select, fast oscillator enable and glitch-free CPU clock
// switch between the slow and fast oscillators.
// Assumes both oscillator waveforms are far slower than clk_i, so that
// each phase spans several clk_i cycles, and an AHB-Lite master.
//
// Notes on behaviour
// - Instruction time is clocks over CPU rate.
// - One 4-bit control register: select, enable, voltage.
// - Voltage field 00/01/1x gives three core levels.
// - Voltage field clears to zero at reset.
// - RC slow oscillator never gives lowest level.
// - Enable bit starts/stops fast oscillator, reads back.
// - Select bit picks CPU clock, reads back.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
module dosc_ctrl #(
    parameter int FAST_STABLE_CYC = dosc_pkg::FAST_STABLE_CYCLES,
    parameter int VSEL_HOLD_CYC = dosc_pkg::VSEL_HOLD_CYCLES,
    parameter int INSTR_CLK = dosc_pkg::INSTR_CLOCKS
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic slow_osc_i,
    input wire logic fast_osc_i,
    input wire logic slow_osc_rc_i,
    output logic fast_osc_enable_o,
    output dosc_pkg::dosc_level_type core_supply_level_o,
    output logic cpu_clk_o,
    output logic cpu_on_fast_o,
    output logic instr_strobe_o
);
    import dosc_pkg::*;
    default clocking sys_cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    localparam int STAB_W = $clog2(FAST_STABLE_CYC + 1);
    localparam int HOLD_W = $clog2(VSEL_HOLD_CYC + 1);
    localparam int INS_W = $clog2(INSTR_CLK + 1);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] pins_s;
    dosc_sync #(.W(SYNC_W)) u_sync (.clk_i(clk_i), .resetn_i(resetn_i),
        .async_i({slow_osc_rc_i, fast_osc_i, slow_osc_i}), .sync_o(pins_s));

    wire slow_s = pins_s[SYNC_SLOW];
    wire fast_s = pins_s[SYNC_FAST];
    wire rc_s = pins_s[SYNC_RC];

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    dosc_ctrl_type ctrl_q;
    dosc_ctrl_type ctrl_d;
    dosc_stat_type stat_q;
    logic addr_ok;
    logic dp_q;
    logic dp_write_q;
    logic [31:0] addr_q;
    logic ctrl_wr;

    // hsize is not checked: every access is treated as a full word
    assign addr_ok = hsel_i && htrans_i[1] && hready_i;
    assign ctrl_wr = dp_q && dp_write_q && (addr_q == OSC_CTRL_ADDR);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dp_q <= 1'b0;
            dp_write_q <= 1'b0;
            addr_q <= '0;
        end else begin
            dp_q <= addr_ok;
            dp_write_q <= addr_ok && hwrite_i;
            if (addr_ok) begin
                addr_q <= haddr_i;
            end
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = dosc_ctrl_type'(hwdata_i[3:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_q <= dosc_ctrl_type'(OSC_CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Read data come from the next control value so that a read right
    // behind a write already sees the written value
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            hrdata_o <= RDATA_ZERO;
        end else if (addr_ok && !hwrite_i) begin
            if (haddr_i == OSC_CTRL_ADDR) begin
                hrdata_o <= {28'h0000000, ctrl_d};
            end else if (haddr_i == OSC_STAT_ADDR) begin
                hrdata_o <= {28'h0000000, stat_q};
            end else begin
                hrdata_o <= RDATA_ZERO;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        hreadyout_o <= 1'b1;
        hresp_o <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Core supply level and fast oscillator enable
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            core_supply_level_o <= LVL_1V2;
        end else if (ctrl_q.core_voltage_select_hi) begin
            core_supply_level_o <= LVL_3V0;
        end else if (ctrl_q.core_voltage_select_lo || rc_s) begin
            core_supply_level_o <= LVL_2V1;
        end else begin
            core_supply_level_o <= LVL_1V2;
        end
    end

    assign fast_osc_enable_o = ctrl_q.fast_osc_enable;

    // ----------------------------------------------------------------
    // Status: fast oscillator warm-up and voltage hold timers
    // ----------------------------------------------------------------
    logic [STAB_W-1:0] stab_cnt_q;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic vsel_change;

    // Timers only advise software; the hardware never blocks a write
    assign vsel_change = (ctrl_d.core_voltage_select_hi != ctrl_q.core_voltage_select_hi)
        || (ctrl_d.core_voltage_select_lo != ctrl_q.core_voltage_select_lo);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            stab_cnt_q <= '0;
        end else if (!ctrl_q.fast_osc_enable) begin
            stab_cnt_q <= '0;
        end else if (stab_cnt_q != STAB_W'(FAST_STABLE_CYC)) begin
            stab_cnt_q <= stab_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            hold_cnt_q <= '0;
        end else if (vsel_change) begin
            hold_cnt_q <= '0;
        end else if (hold_cnt_q != HOLD_W'(VSEL_HOLD_CYC)) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
        end
    end

    dosc_sw_type sw_q;
    logic on_fast_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            stat_q <= '0;
        end else begin
            stat_q.fast_osc_stable <= ctrl_q.fast_osc_enable && (stab_cnt_q == STAB_W'(FAST_STABLE_CYC));
            stat_q.cpu_on_fast <= on_fast_q;
            stat_q.switching <= (sw_q != SW_RUN);
            stat_q.voltage_settled <= (hold_cnt_q == HOLD_W'(VSEL_HOLD_CYC));
        end
    end

    // ----------------------------------------------------------------
    // Glitch-free CPU clock switch
    // ----------------------------------------------------------------
    // The old source is let finish its high phase and parked low, then the
    // new source is joined just after it falls, so its low phase is whole.
    // If the fast oscillator is stopped while selected, the switch waits.
    logic old_src;
    logic src_prev_q;

    assign old_src = on_fast_q ? fast_s : slow_s;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sw_q <= SW_RUN;
            on_fast_q <= 1'b0;
            cpu_clk_o <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= old_src;
            unique case (sw_q)
                SW_RUN: begin
                    cpu_clk_o <= old_src;
                    if (ctrl_q.cpu_clock_select != on_fast_q) begin
                        sw_q <= SW_PARK;
                    end
                end
                SW_PARK: begin
                    cpu_clk_o <= old_src;
                    if (!old_src) begin
                        sw_q <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    cpu_clk_o <= 1'b0;
                    on_fast_q <= ctrl_q.cpu_clock_select;
                    sw_q <= SW_SETTLE;
                end
                SW_SETTLE: begin
                    cpu_clk_o <= 1'b0;
                    if (!old_src && src_prev_q) begin
                        sw_q <= SW_RUN;
                    end
                end
            endcase
        end
    end

    assign cpu_on_fast_o = on_fast_q;

    // ----------------------------------------------------------------
    // Instruction timing strobe
    // ----------------------------------------------------------------
    logic clk_prev_q;
    logic cpu_rise;
    logic [INS_W-1:0] ins_cnt_q;

    assign cpu_rise = cpu_clk_o && !clk_prev_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            clk_prev_q <= 1'b0;
            ins_cnt_q <= '0;
            instr_strobe_o <= 1'b0;
        end else begin
            clk_prev_q <= cpu_clk_o;
            instr_strobe_o <= cpu_rise && (ins_cnt_q == INS_W'(INSTR_CLK - 1));
            if (cpu_rise) begin
                ins_cnt_q <= (ins_cnt_q == INS_W'(INSTR_CLK - 1)) ? '0 : ins_cnt_q + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [INS_W-1:0] chk_rise_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            chk_rise_q <= '0;
        end else if (instr_strobe_o) begin
            chk_rise_q <= cpu_rise ? INS_W'(1) : '0;
        end else if (cpu_rise) begin
            chk_rise_q <= chk_rise_q + 1'b1;
        end
    end

    property p_reset_clear;
        $rose(resetn_i) |-> (ctrl_q == dosc_ctrl_type'(OSC_CTRL_RESET)) ##1 !fast_osc_enable_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control register not clear after reset");

    property p_level_map;
        (ctrl_q.core_voltage_select_hi && $past(ctrl_q.core_voltage_select_hi)) |-> core_supply_level_o == LVL_3V0;
    endproperty
    a_level_map: assert property (p_level_map)
        else $error("high voltage select did not give top level");

    property p_rc_level;
        ($past(rc_s) && $past(resetn_i)) |-> core_supply_level_o != LVL_1V2;
    endproperty
    a_rc_level: assert property (p_rc_level)
        else $error("lowest level with RC slow oscillator");

    property p_enable_write;
        ctrl_wr |=> fast_osc_enable_o == $past(hwdata_i[2]) && ctrl_q.cpu_clock_select == $past(hwdata_i[3]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("control write not taken");

    property p_read_back;
        (dp_q && !dp_write_q && addr_q == OSC_CTRL_ADDR) |-> hrdata_o == {28'h0000000, ctrl_q};
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("control read back wrong");

    property p_unmapped;
        (dp_q && !dp_write_q && addr_q != OSC_CTRL_ADDR && addr_q != OSC_STAT_ADDR) |-> hrdata_o == RDATA_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_no_runt;
        $rose(cpu_clk_o) |-> cpu_clk_o [*3];
    endproperty
    a_no_runt: assert property (p_no_runt)
        else $error("short CPU clock high pulse");

    property p_switch_low;
        $changed(cpu_on_fast_o) |-> !cpu_clk_o && !$past(cpu_clk_o) ##1 !cpu_clk_o;
    endproperty
    a_switch_low: assert property (p_switch_low)
        else $error("CPU clock not parked low across switch");

    property p_instr_count;
        instr_strobe_o |-> chk_rise_q == INS_W'(INSTR_CLK) ##1 !instr_strobe_o;
    endproperty
    a_instr_count: assert property (p_instr_count)
        else $error("instruction strobe after wrong clock count");

endmodule

// ==== testbench/dosc_osc_model.sv ====
// Behavioural slow and fast oscillator sources for the clock control bench.
// Assumes half periods far longer than the 40 ns system clock.
`timescale 1ns/1ps
module dosc_osc_model #(
    parameter int SLOW_HALF_NS = 491,
    parameter int FAST_HALF_NS = 213
) (
    input wire logic fast_osc_enable_i,
    output logic slow_osc_o,
    output logic fast_osc_o
);
    // ----------------------------------------------------------------
    // Sources
    // ----------------------------------------------------------------
    // Odd half periods keep source edges off system clock edges, except every 20th edge of each source
    logic slow_q = 1'b0;

    always #(SLOW_HALF_NS) slow_q = ~slow_q;
    assign slow_osc_o = slow_q;

    // A stopped oscillator stands low instead of holding its last level
    always begin
        if (fast_osc_enable_i === 1'b1) begin
            #(FAST_HALF_NS) fast_osc_o = ~fast_osc_o;
        end else begin
            fast_osc_o = 1'b0;
            @(posedge fast_osc_enable_i);
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the dual oscillator clock control block.
// Assumes the design package and the oscillator model are compiled first.
`timescale 1ns/1ps
module testbench;
    import dosc_pkg::*;
    localparam int HOLD = 20;
    localparam int LIMIT = 20000;
    localparam logic [31:0] CTRL = OSC_CTRL_ADDR;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic slow_osc_rc_i = 1'b0;
    logic hreadyout_o, hresp_o, cpu_clk_o, cpu_on_fast_o, instr_strobe_o;
    logic slow_osc, fast_osc, fast_osc_enable_o, prev_clk;
    logic [31:0] hrdata_o;
    logic [31:0] rd;
    dosc_level_type core_supply_level_o;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int rises = 0;
    int gap = 0;
    int run = 0;
    int min_run = 1000;

    always #20 clk_i = ~clk_i;

    dosc_ctrl #(.FAST_STABLE_CYC(HOLD), .VSEL_HOLD_CYC(HOLD), .INSTR_CLK(5)) dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .slow_osc_i(slow_osc), .fast_osc_i(fast_osc),
        .slow_osc_rc_i(slow_osc_rc_i), .fast_osc_enable_o(fast_osc_enable_o),
        .core_supply_level_o(core_supply_level_o), .cpu_clk_o(cpu_clk_o),
        .cpu_on_fast_o(cpu_on_fast_o), .instr_strobe_o(instr_strobe_o));

    dosc_osc_model osc_u (.fast_osc_enable_i(fast_osc_enable_o), .slow_osc_o(slow_osc), .fast_osc_o(fast_osc));

    // ----------------------------------------------------------------
    // Monitors: CPU clock rises per strobe, shortest clock phase, hang
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        prev_clk <= cpu_clk_o;
        if (instr_strobe_o === 1'b1) begin
            gap <= rises;
            rises <= (cpu_clk_o === 1'b1 && prev_clk === 1'b0) ? 1 : 0;
        end else if (cpu_clk_o === 1'b1 && prev_clk === 1'b0) begin
            rises <= rises + 1;
        end
        if (cpu_clk_o !== prev_clk) begin
            if (run < min_run && resetn_i === 1'b1) min_run <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
        if (cycles == LIMIT) begin
            mismatches++;
            $display("unexpected at %0t: run did not finish", $time);
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    task automatic chk_lvl(input dosc_level_type exp);
        comparisons++;
        if (core_supply_level_o !== exp) begin
            mismatches++;
            $display("unexpected at %0t: level %h, wanted %h", $time, core_supply_level_o, exp);
        end
    endtask

    // Single AHB transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= addr;
        hwrite_i <= wr;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wdata;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask

    task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        chk32(rd, exp);
    endtask

    task automatic pause();
        repeat (4) @(posedge clk_i);
    endtask

    // Status bits lag the control write, so let it land before polling
    task automatic wait_stat(input int idx, input logic v);
        int k;
        k = 0;
        repeat (2) @(posedge clk_i);
        do begin
            bus(1'b0, OSC_STAT_ADDR, 32'h0);
            k++;
        end while (rd[idx] !== v && k < 100);
        chk_bit(rd[idx], v);
    endtask

    task automatic wait_on_fast(input logic v);
        int k;
        k = 0;
        while (cpu_on_fast_o !== v && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        chk_bit(cpu_on_fast_o, v);
    endtask

    // First gap after reset or a switch may be partial, so skip one strobe
    task automatic wait_strobes();
        int k;
        k = 0;
        repeat (2) begin
            @(posedge clk_i);
            while (instr_strobe_o !== 1'b1 && k < 2000) begin
                @(posedge clk_i);
                k++;
            end
        end
        @(posedge clk_i);
        chk32(32'(gap), 32'h5);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        chk_bit(fast_osc_enable_o, 1'b0);
        chk_bit(cpu_on_fast_o, 1'b0);
        chk_lvl(LVL_1V2);
        chk_bit(hresp_o, 1'b0);
        rdchk(CTRL, 32'h0);
        rdchk(32'h0000_0f78, 32'h0);
        bus(1'b1, 32'h0000_0f78, 32'hffff_ffff);
        bus(1'b1, OSC_STAT_ADDR, 32'hffff_ffff);
        rdchk(CTRL, 32'h0);
        wait_strobes();
        // Upper data bits must be dropped by the register
        bus(1'b1, CTRL, 32'hffff_fff1);
        rdchk(CTRL, 32'h1);
        pause();
        chk_lvl(LVL_2V1);
        wait_stat(3, 1'b1);
        bus(1'b1, CTRL, 32'h2);
        pause();
        chk_lvl(LVL_3V0);
        bus(1'b1, CTRL, 32'h3);
        pause();
        chk_lvl(LVL_3V0);
        bus(1'b1, CTRL, 32'h7);
        pause();
        chk_bit(fast_osc_enable_o, 1'b1);
        rdchk(CTRL, 32'h7);
        wait_stat(0, 1'b1);
        bus(1'b1, CTRL, 32'hf);
        wait_on_fast(1'b1);
        rdchk(CTRL, 32'hf);
        wait_strobes();
        rdchk(OSC_STAT_ADDR, 32'hb);
        bus(1'b1, CTRL, 32'h7);
        wait_on_fast(1'b0);
        bus(1'b1, CTRL, 32'h3);
        pause();
        chk_bit(fast_osc_enable_o, 1'b0);
        chk_bit(min_run >= 4, 1'b1);
        bus(1'b1, CTRL, 32'h1);
        wait_stat(3, 1'b1);
        rdchk(OSC_STAT_ADDR, 32'h8);
        bus(1'b1, CTRL, 32'h0);
        pause();
        chk_lvl(LVL_1V2);
        slow_osc_rc_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk_lvl(LVL_2V1);
        slow_osc_rc_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk_lvl(LVL_1V2);
        print_verdict();
    end
endmodule
